// [pkg/rsi_pkg.sv]
// package: reset kinds, flag positions, reset values and port widths for the reset init block
package rsi_pkg;
    // latched reset kind
    typedef enum logic [1:0] {
        RSI_KIND_NONE     = 2'b00,
        RSI_KIND_POR      = 2'b01,
        RSI_KIND_WDT_RUN  = 2'b11,
        RSI_KIND_WDT_IDLE = 2'b10
    } rsi_kind_t;

    // sequencer states, gray along run -> hold -> apply -> release
    typedef enum logic [1:0] {
        RSI_ST_RUN     = 2'b00,
        RSI_ST_HOLD    = 2'b01,
        RSI_ST_APPLY   = 2'b11,
        RSI_ST_RELEASE = 2'b10
    } rsi_state_t;

    // status register flag positions
    localparam int RSI_TMO_BIT   = 5;
    localparam int RSI_PWRDN_BIT = 4;

    // widths and reset values
    localparam int          RSI_PC_W        = 13;
    localparam int          RSI_SP_W        = 4;
    localparam int          RSI_PORT_W      = 8;
    localparam logic [12:0] RSI_PC_RST      = 13'h0000;
    localparam logic [3:0]  RSI_SP_TOP      = 4'h0;
    localparam logic [3:0]  RSI_SP_ZERO     = 4'h0;
    localparam logic [7:0]  RSI_PORT_DIR_IN = 8'hff;
    localparam logic [7:0]  RSI_WDOG_RST    = 8'h53;
    localparam logic [7:0]  RSI_DIP_LVL_RST = 8'h66;
    localparam logic [1:0]  RSI_DIP_WID_RST = 2'h1;
endpackage

// [pkg/rsi_flag_if.sv]
// interface: flag update request between sequencer and flag keeper
`timescale 1ns/1ps
interface rsi_flag_if;
    logic      upd;
    logic      tmo_val;
    logic      pwrdn_val;
    logic      tmo_keep;
    logic      pwrdn_keep;
    modport seq  (output upd, output tmo_val, output pwrdn_val,
                  output tmo_keep, output pwrdn_keep);
    modport keep (input upd, input tmo_val, input pwrdn_val,
                  input tmo_keep, input pwrdn_keep);
endinterface

// [rtl/rsi_flags.sv]
// status flag keeper: timeout and power-down flags
`timescale 1ns/1ps
module rsi_flags
    import rsi_pkg::*;
(
    // clock and reset
    input  wire logic  clk_sys_in,
    input  wire logic  rst_in,
    // reset-time update request
    rsi_flag_if.keep   req,
    // run-time operations
    input  wire logic  sleep_entry_in,
    input  wire logic  wdt_clear_in,
    // flags
    output logic       timeout_flag_out,
    output logic       powerdown_flag_out
);
    // flags live through resets other than power-on; the update carries them
    always_ff @(posedge clk_sys_in) begin
        if (req.upd) begin
            if (!req.tmo_keep) begin
                timeout_flag_out <= req.tmo_val;
            end
            if (!req.pwrdn_keep) begin
                powerdown_flag_out <= req.pwrdn_val;
            end
        end else if (rst_in) begin
            timeout_flag_out   <= timeout_flag_out;
            powerdown_flag_out <= powerdown_flag_out;
        end else if (sleep_entry_in) begin
            // sleep entry: clear timeout, set power-down
            timeout_flag_out   <= 1'b0;
            powerdown_flag_out <= 1'b1;
        end else if (wdt_clear_in) begin
            timeout_flag_out   <= 1'b0;
            powerdown_flag_out <= 1'b0;
        end
    end
endmodule

// [rtl/rsi_reset_init.sv]
// reset initial state sequencer: latches reset kind and strobes register initialisation
`timescale 1ns/1ps
// Summary of operation
// - timeout and power-down flags kept; sleep and watchdog events update them.
// - power-on reset clears both flags.
// - supply dip reset while running leaves both flags unchanged.
// - watchdog reset while running sets timeout, keeps power-down.
// - watchdog reset in idle or sleep sets both flags.
// - power-on: program counter to zero, all interrupts disabled.
// - power-on: watchdog and time bases cleared, watchdog restarts counting.
// - power-on: all timer modules switched off.
// - power-on: every port direction set to input.
// - power-on: stack pointer set to top of stack.
// - each register per reset type loaded, left unknown, or preserved.
// - watchdog reset in idle clears only program counter and stack pointer.
// - watchdog reset while running initialises like supply dip reset.
module rsi_reset_init
    import rsi_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_in,
    // reset sources, high while the source holds the reset
    input  wire logic                  por_in,
    input  wire logic                  supply_dip_reset_in,
    input  wire logic                  wdt_timeout_in,
    // core mode and run-time flag events
    input  wire logic                  low_power_mode_in,
    input  wire logic                  sleep_entry_in,
    input  wire logic                  wdt_clear_in,
    // status flags
    output logic                       timeout_flag_out,
    output logic                       powerdown_flag_out,
    // core state
    output logic [RSI_PC_W-1:0]        pc_out,
    output logic [RSI_SP_W-1:0]        sp_out,
    output logic                       core_hold_out,
    output logic                       fetch_go_out,
    // register initialisation strobes
    output logic                       init_full_out,
    output logic                       init_por_only_out,
    output logic                       int_disable_out,
    output logic                       wdt_tb_clear_out,
    output logic                       wdt_run_out,
    output logic                       timers_off_out,
    output logic [RSI_PORT_W-1:0]      port_dir_out,
    output logic                       port_dir_load_out,
    output logic [7:0]                 wdog_init_out,
    output logic [7:0]                 dip_lvl_init_out,
    output logic [1:0]                 dip_wid_init_out,
    output rsi_kind_t                  kind_out
);
    rsi_state_t state_r;
    rsi_state_t state_nxt;
    rsi_kind_t  kind_r;
    logic       any_src;
    logic       full_r;
    logic       por_step;
    logic       apply;
    logic       fresh;

    rsi_flag_if flag_bus ();

    // priority: power-on over watchdog over supply dip
    function automatic rsi_kind_t kind_of(input logic por, input logic wdt,
                                          input logic idle);
        if (por) begin
            kind_of = RSI_KIND_POR;
        end else if (wdt && idle) begin
            kind_of = RSI_KIND_WDT_IDLE;
        end else if (wdt) begin
            kind_of = RSI_KIND_WDT_RUN;
        end else begin
            kind_of = RSI_KIND_NONE;
        end
    endfunction

    assign any_src = por_in | supply_dip_reset_in | wdt_timeout_in;

    // a source in release starts a new sequence, so it must latch afresh
    assign fresh = (state_r == RSI_ST_RUN) || (state_r == RSI_ST_RELEASE);

    // latch reset kind
    // only a later power-on source during hold upgrades the kind, never downgrades
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            kind_r <= RSI_KIND_POR;
            full_r <= 1'b0;
        end else if (any_src && state_r != RSI_ST_APPLY) begin
            if (fresh || por_in) begin
                kind_r <= kind_of(por_in, wdt_timeout_in, low_power_mode_in);
            end
            full_r <= supply_dip_reset_in | (full_r & !fresh);
        end
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RSI_ST_RUN: begin
                if (any_src) begin
                    state_nxt = RSI_ST_HOLD;
                end
            end
            RSI_ST_HOLD: begin
                if (!any_src) begin
                    state_nxt = RSI_ST_APPLY;
                end
            end
            RSI_ST_APPLY: begin
                state_nxt = RSI_ST_RELEASE;
            end
            RSI_ST_RELEASE: begin
                state_nxt = any_src ? RSI_ST_HOLD : RSI_ST_RUN;
            end
            default: begin
                state_nxt = RSI_ST_HOLD;
            end
        endcase
    end

    // system reset behaves as a power-on
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r <= RSI_ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign apply    = (state_r == RSI_ST_APPLY);
    assign por_step = apply && kind_r == RSI_KIND_POR;

    always_comb begin
        flag_bus.upd        = apply;
        flag_bus.tmo_val    = 1'b0;
        flag_bus.pwrdn_val  = 1'b0;
        flag_bus.tmo_keep   = 1'b1;
        flag_bus.pwrdn_keep = 1'b1;
        case (kind_r)
            RSI_KIND_POR: begin
                flag_bus.tmo_keep   = 1'b0;
                flag_bus.pwrdn_keep = 1'b0;
            end
            RSI_KIND_WDT_RUN: begin
                flag_bus.tmo_val  = 1'b1;
                flag_bus.tmo_keep = 1'b0;
            end
            RSI_KIND_WDT_IDLE: begin
                flag_bus.tmo_val    = 1'b1;
                flag_bus.pwrdn_val  = 1'b1;
                flag_bus.tmo_keep   = 1'b0;
                flag_bus.pwrdn_keep = 1'b0;
            end
            default: begin
                flag_bus.tmo_keep = 1'b1;
            end
        endcase
    end

    rsi_flags u_flags (
        .clk_sys_in         (clk_sys_in),
        .rst_in             (rst_in),
        .req                (flag_bus.keep),
        .sleep_entry_in     (sleep_entry_in & ~core_hold_out),
        .wdt_clear_in       (wdt_clear_in & ~core_hold_out),
        .timeout_flag_out   (timeout_flag_out),
        .powerdown_flag_out (powerdown_flag_out)
    );

    // core pointers reset on every kind
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pc_out <= RSI_PC_RST;
            sp_out <= RSI_SP_TOP;
        end else if (apply) begin
            pc_out <= RSI_PC_RST;
            sp_out <= (kind_r == RSI_KIND_WDT_IDLE) ? RSI_SP_ZERO : RSI_SP_TOP;
        end
    end

    // hold core until the release step after the one-step apply ends
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            core_hold_out <= 1'b1;
            fetch_go_out  <= 1'b0;
        end else begin
            core_hold_out <= (state_nxt != RSI_ST_RUN);
            fetch_go_out  <= (state_r == RSI_ST_RELEASE) && !any_src;
        end
    end

    // per-kind register load strobes
    // watchdog while running loads the same set as a supply dip; idle pulses no load strobe
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            init_full_out     <= 1'b0;
            init_por_only_out <= 1'b0;
            kind_out          <= RSI_KIND_NONE;
        end else begin
            init_full_out     <= apply && (kind_r == RSI_KIND_POR ||
                                           kind_r == RSI_KIND_WDT_RUN || full_r);
            init_por_only_out <= por_step;
            kind_out          <= apply ? kind_r : kind_out;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            int_disable_out   <= 1'b0;
            wdt_tb_clear_out  <= 1'b0;
            timers_off_out    <= 1'b0;
            port_dir_load_out <= 1'b0;
        end else begin
            int_disable_out   <= por_step;
            wdt_tb_clear_out  <= por_step;
            timers_off_out    <= por_step;
            port_dir_load_out <= por_step;
        end
    end

    // watchdog counts again as soon as hold lifts
    assign wdt_run_out = ~core_hold_out;

    assign port_dir_out   = RSI_PORT_DIR_IN;
    assign wdog_init_out    = RSI_WDOG_RST;
    assign dip_lvl_init_out = RSI_DIP_LVL_RST;
    assign dip_wid_init_out = RSI_DIP_WID_RST;
endmodule

// [verif/rsi_reset_init_checker.sv]
// checker: port-level timing and value relations of the reset init sequencer
`timescale 1ns/1ps
module rsi_reset_init_checker
    import rsi_pkg::*;
(
    // clock, reset and reset sources
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              por_in,
    input  wire logic              supply_dip_reset_in,
    input  wire logic              wdt_timeout_in,
    // observed design outputs
    input  wire logic              timeout_flag_out,
    input  wire logic              powerdown_flag_out,
    input  wire logic [RSI_PC_W-1:0] pc_out,
    input  wire logic [RSI_SP_W-1:0] sp_out,
    input  wire logic              core_hold_out,
    input  wire logic              fetch_go_out,
    input  wire logic              init_full_out,
    input  wire logic              init_por_only_out,
    input  wire logic              int_disable_out,
    input  wire logic              wdt_tb_clear_out,
    input  wire logic              wdt_run_out,
    input  wire logic              timers_off_out,
    input  wire logic [RSI_PORT_W-1:0] port_dir_out,
    input  wire logic              port_dir_load_out,
    input  wire logic [7:0]        wdog_init_out,
    input  wire rsi_kind_t         kind_out
);
    // one domain, so clock and disable are given once
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_por_flags_clear: assert property (
        init_por_only_out |-> !timeout_flag_out && !powerdown_flag_out)
        else $error("power-on apply left a flag set");
    a_por_strobe_set: assert property (
        init_por_only_out |-> int_disable_out && wdt_tb_clear_out && timers_off_out
            && port_dir_load_out && init_full_out)
        else $error("power-on strobes not issued together");
    a_init_values: assert property (
        init_full_out |-> pc_out == RSI_PC_RST && sp_out == RSI_SP_TOP
            && port_dir_out == RSI_PORT_DIR_IN && wdog_init_out == RSI_WDOG_RST)
        else $error("reset values wrong during load");
    a_fetch_follows: assert property (
        init_full_out |=> fetch_go_out && !core_hold_out)
        else $error("fetch not released one cycle after load");
    a_wdt_restart: assert property (
        $fell(core_hold_out) |-> wdt_run_out && fetch_go_out)
        else $error("watchdog not counting at release");
    a_hold_on_src: assert property (
        !core_hold_out && (por_in || supply_dip_reset_in || wdt_timeout_in) |=> core_hold_out)
        else $error("reset source not taken");
    a_idle_both_set: assert property (
        fetch_go_out && kind_out == RSI_KIND_WDT_IDLE |-> timeout_flag_out
            && powerdown_flag_out && pc_out == RSI_PC_RST && sp_out == RSI_SP_ZERO)
        else $error("idle watchdog reset state wrong");
    a_run_to_set: assert property (
        fetch_go_out && kind_out == RSI_KIND_WDT_RUN |-> timeout_flag_out)
        else $error("running watchdog reset left timeout clear");
    a_strobe_single: assert property (
        init_por_only_out |=> !init_por_only_out && !init_full_out)
        else $error("load strobe longer than one cycle");

    // main scenarios reached
    c_por: cover property (init_por_only_out);
    c_idle: cover property (fetch_go_out && kind_out == RSI_KIND_WDT_IDLE);
    c_run: cover property (fetch_go_out && kind_out == RSI_KIND_WDT_RUN);
    c_dip: cover property (fetch_go_out && kind_out == RSI_KIND_NONE);
endmodule

// [verif/testbench.sv]
// testbench: drives reset sources and flag events, judges flags, kind and strobes
`timescale 1ns/1ps
module testbench;
    import rsi_pkg::*;
    logic clk_sys_in, rst_in, por_in, supply_dip_reset_in, wdt_timeout_in;
    logic low_power_mode_in, sleep_entry_in, wdt_clear_in;
    logic timeout_flag_out, powerdown_flag_out, core_hold_out, fetch_go_out;
    logic init_full_out, init_por_only_out, int_disable_out, wdt_tb_clear_out;
    logic wdt_run_out, timers_off_out, port_dir_load_out;
    logic [RSI_PC_W-1:0] pc_out;
    logic [RSI_SP_W-1:0] sp_out;
    logic [RSI_PORT_W-1:0] port_dir_out;
    logic [7:0] wdog_init_out, dip_lvl_init_out;
    logic [1:0] dip_wid_init_out;
    rsi_kind_t kind_out;
    int mismatches = 0, n_tests = 0, cyc = 0;
    logic full_seen, por_seen;

    rsi_reset_init uut (.clk_sys_in, .rst_in, .por_in, .supply_dip_reset_in, .wdt_timeout_in,
        .low_power_mode_in, .sleep_entry_in, .wdt_clear_in, .timeout_flag_out,
        .powerdown_flag_out, .pc_out, .sp_out, .core_hold_out, .fetch_go_out, .init_full_out,
        .init_por_only_out, .int_disable_out, .wdt_tb_clear_out, .wdt_run_out, .timers_off_out,
        .port_dir_out, .port_dir_load_out, .wdog_init_out, .dip_lvl_init_out, .dip_wid_init_out,
        .kind_out);

    // free-running clock, 4 ns
    initial begin
        clk_sys_in = 0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard, far above the under one hundred cycles needed
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // bounded wait for release, noting which load strobes pulsed
    task automatic wait_fetch();
        full_seen = 0;
        por_seen = 0;
        for (int i = 0; i < 40 && fetch_go_out !== 1'b1; i++) begin
            @(posedge clk_sys_in);
            #1;
            full_seen |= (init_full_out === 1'b1);
            por_seen |= (init_por_only_out === 1'b1);
        end
        chk(fetch_go_out, 1'b1, "fetch release");
    endtask

    // one-cycle reset source pulse {por, dip, wdt}
    task automatic fire(input logic [2:0] src, input logic idle);
        @(posedge clk_sys_in);
        {por_in, supply_dip_reset_in, wdt_timeout_in} <= src;
        low_power_mode_in <= idle;
        @(posedge clk_sys_in);
        {por_in, supply_dip_reset_in, wdt_timeout_in} <= 3'b000;
        wait_fetch();
    endtask

    task automatic sw_event(input logic s, input logic c);
        @(posedge clk_sys_in);
        sleep_entry_in <= s;
        wdt_clear_in <= c;
        @(posedge clk_sys_in);
        sleep_entry_in <= 1'b0;
        wdt_clear_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic expect_state(input logic tmo, input logic pwrdn, input rsi_kind_t k);
        chk(timeout_flag_out, tmo, "timeout flag");
        chk(powerdown_flag_out, pwrdn, "powerdown flag");
        chk(kind_out, k, "kind");
        chk(pc_out, RSI_PC_RST, "pc");
    endtask

    task automatic t_power_on();
        wait_fetch();
        expect_state(1'b0, 1'b0, RSI_KIND_POR);
        chk(por_seen, 1'b1, "por strobes");
        chk(sp_out, RSI_SP_TOP, "stack top");
        chk(dip_lvl_init_out, RSI_DIP_LVL_RST, "supply level reset");
        chk(dip_wid_init_out, RSI_DIP_WID_RST, "dip width reset");
        chk(wdog_init_out, RSI_WDOG_RST, "watchdog control reset");
        chk(port_dir_out, RSI_PORT_DIR_IN, "ports as inputs");
        chk(wdt_run_out, 1'b1, "watchdog running");
    endtask

    task automatic t_sw_events();
        sw_event(1'b1, 1'b0);
        expect_state(1'b0, 1'b1, RSI_KIND_POR);
        sw_event(1'b0, 1'b1);
        expect_state(1'b0, 1'b0, RSI_KIND_POR);
    endtask

    task automatic t_wdt_run();
        sw_event(1'b1, 1'b0);
        fire(3'b001, 1'b0);
        expect_state(1'b1, 1'b1, RSI_KIND_WDT_RUN);
        chk({por_seen, full_seen}, 2'b01, "running load");
    endtask

    task automatic t_dip();
        fire(3'b010, 1'b0);
        expect_state(1'b1, 1'b1, RSI_KIND_NONE);
        chk({por_seen, full_seen}, 2'b01, "dip load");
        sw_event(1'b0, 1'b1);
        fire(3'b010, 1'b0);
        expect_state(1'b0, 1'b0, RSI_KIND_NONE);
    endtask

    task automatic t_wdt_idle();
        fire(3'b001, 1'b1);
        expect_state(1'b1, 1'b1, RSI_KIND_WDT_IDLE);
        chk({por_seen, full_seen}, 2'b00, "idle keeps registers");
        chk(sp_out, RSI_SP_ZERO, "idle stack");
    endtask

    task automatic t_priority();
        fire(3'b101, 1'b1);
        expect_state(1'b0, 1'b0, RSI_KIND_POR);
        chk(por_seen, 1'b1, "por wins");
    endtask

    // events refused while held; power-on arriving during hold upgrades the kind
    task automatic t_hold();
        @(posedge clk_sys_in);
        supply_dip_reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sleep_entry_in <= 1'b1;
        @(posedge clk_sys_in);
        sleep_entry_in <= 1'b0;
        @(posedge clk_sys_in);
        supply_dip_reset_in <= 1'b0;
        wait_fetch();
        expect_state(1'b0, 1'b0, RSI_KIND_NONE);
        @(posedge clk_sys_in);
        wdt_timeout_in <= 1'b1;
        low_power_mode_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        por_in <= 1'b1;
        @(posedge clk_sys_in);
        {por_in, wdt_timeout_in} <= 2'b00;
        wait_fetch();
        expect_state(1'b0, 1'b0, RSI_KIND_POR);
        chk(por_seen, 1'b1, "upgrade to power-on");
    endtask

    // reset for 20 cycles, then the scenarios in turn
    initial begin
        {rst_in, por_in, supply_dip_reset_in, wdt_timeout_in} = 4'h8;
        {low_power_mode_in, sleep_entry_in, wdt_clear_in} = 3'b000;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_power_on();
        t_sw_events();
        t_wdt_run();
        t_dip();
        t_wdt_idle();
        t_priority();
        t_hold();
        tally_and_finish();
    end
endmodule

bind rsi_reset_init rsi_reset_init_checker chk_i (.clk_sys_in, .rst_in, .por_in,
    .supply_dip_reset_in, .wdt_timeout_in, .timeout_flag_out, .powerdown_flag_out, .pc_out,
    .sp_out, .core_hold_out, .fetch_go_out, .init_full_out, .init_por_only_out,
    .int_disable_out, .wdt_tb_clear_out, .wdt_run_out, .timers_off_out, .port_dir_out,
    .port_dir_load_out, .wdog_init_out, .kind_out);
